// [hdl/sbm_pkg.sv]
// Purpose: shared constants and types for the serial byte memory slave
// Assumes: one 25 MHz core clock, synchronous active-low reset
// Notes: slave byte layout is type[7:4], select[3:2], page[1], read[0]
package sbm_pkg;
   localparam int SBM_DW = 8;
   localparam int SBM_AW = 9;
   localparam int SBM_DEPTH = 512;
   localparam int SBM_CNT_W = 3;
   // fields of the first byte after a start condition
   localparam int SBM_TYPE_MSB = 7;
   localparam int SBM_TYPE_LSB = 4;
   localparam int SBM_SEL_MSB = 3;
   localparam int SBM_SEL_LSB = 2;
   localparam int SBM_PAGE_BIT = 1;
   localparam int SBM_RW_BIT = 0;
   // index of each pin in the synchronised input vector
   localparam int SBM_IN_W = 5;
   localparam int SBM_IN_SCL = 4;
   localparam int SBM_IN_SDA = 3;
   localparam int SBM_IN_SEL_MSB = 2;
   localparam int SBM_IN_SEL_LSB = 1;
   localparam int SBM_IN_WP = 0;
   // values after reset, and the last bit count of a byte
   localparam logic [SBM_AW-1:0] SBM_ADDR_RST = 9'h000;
   localparam logic [SBM_DW-1:0] SBM_BYTE_RST = 8'h00;
   localparam logic [SBM_CNT_W-1:0] SBM_CNT_RST = 3'h0;
   localparam logic [SBM_CNT_W-1:0] SBM_CNT_LAST = 3'h7;
   localparam logic SBM_BIT_RST = 1'b0;
   // the bus sits released and high when idle
   localparam logic SBM_LINE_IDLE = 1'b1;

   typedef enum logic [3:0] {
      SBM_IDLE,
      SBM_DEV,
      SBM_WORD,
      SBM_WDAT,
      SBM_ACK_SET,
      SBM_ACK_HOLD,
      SBM_RDAT,
      SBM_MREL,
      SBM_MACK,
      SBM_MNEXT
   } sbm_state_t;
endpackage

// [hdl/sbm_mem.sv]
// Purpose: byte array with one write port and a registered read port
// Assumes: single clock, write and read in the same cycle are allowed
// Notes: contents have no reset, the array models nonvolatile storage
`timescale 1ns/1ns
module sbm_mem #(
   parameter int DW = 8,
   parameter int AW = 9,
   parameter int DEPTH = 512
) (
   input wire logic core_clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data_ff
);
   logic [DW-1:0] array_ff [DEPTH];

   // write port: one byte per pulse
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         array_ff[wr_addr] <= wr_data;
      end
   end

   // read data always follows the address one cycle later
   always_ff @(posedge core_clk) begin
      rd_data_ff <= array_ff[rd_addr];
   end
endmodule

// [hdl/sbm_top.sv]
// Purpose: two-wire serial bus slave in front of a 512 byte memory
// Assumes: core_clk at least 25 times the serial clock, master makes the serial clock
// Notes: sda is open drain, the pull-up sits outside
`timescale 1ns/1ns
module sbm_top #(
   // device type code; value is arbitrary
   parameter logic [3:0] DEV_TYPE = 4'h6
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic scl_pin,
   input wire logic sda_in,
   input wire logic [1:0] device_select_straps,
   input wire logic write_protect,
   output logic sda_out_ff,
   output logic sda_oe_ff
);
   import sbm_pkg::*;

   logic [SBM_IN_W-1:0] pin_raw;
   logic [SBM_IN_W-1:0] pin_lvl;
   logic scl_d_ff;
   logic sda_d_ff;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic [SBM_DW-1:0] rx_byte;
   logic dev_match;
   sbm_state_t state_ff;
   sbm_state_t after_ack_ff;
   logic [SBM_CNT_W-1:0] cnt_ff;
   logic [SBM_DW-1:0] shift_ff;
   logic [SBM_DW-1:0] tx_ff;
   logic [SBM_AW-1:0] addr_ff;
   logic page_ff;
   logic wr_pulse;
   logic [SBM_DW-1:0] rd_data;

   assign pin_raw = {scl_pin, sda_in, device_select_straps, write_protect};

   // three-stage synchroniser per pin; a new level counts once stages two and three agree
   generate
      for (genvar i = 0; i < SBM_IN_W; i++) begin : g_sync
         logic s1_ff;
         logic s2_ff;
         logic s3_ff;
         logic lvl_ff;
         // scl and sda idle high; straps and write protect default low
         localparam logic RST_LVL = (i == SBM_IN_SCL || i == SBM_IN_SDA) ? SBM_LINE_IDLE : SBM_BIT_RST;
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               s1_ff <= RST_LVL;
               s2_ff <= RST_LVL;
               s3_ff <= RST_LVL;
               lvl_ff <= RST_LVL;
            end else begin
               s1_ff <= pin_raw[i];
               s2_ff <= s1_ff;
               s3_ff <= s2_ff;
               if (s2_ff == s3_ff) begin
                  lvl_ff <= s3_ff;
               end
            end
         end
         assign pin_lvl[i] = lvl_ff;
      end
   endgenerate

   // previous filtered levels for edge detection
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         scl_d_ff <= SBM_LINE_IDLE;
         sda_d_ff <= SBM_LINE_IDLE;
      end else begin
         scl_d_ff <= pin_lvl[SBM_IN_SCL];
         sda_d_ff <= pin_lvl[SBM_IN_SDA];
      end
   end

   // bus events; sda moving while scl is high is a start or a stop
   assign scl_rise = pin_lvl[SBM_IN_SCL] && !scl_d_ff;
   assign scl_fall = !pin_lvl[SBM_IN_SCL] && scl_d_ff;
   assign start_seen = pin_lvl[SBM_IN_SCL] && scl_d_ff && sda_d_ff && !pin_lvl[SBM_IN_SDA];
   assign stop_seen = pin_lvl[SBM_IN_SCL] && scl_d_ff && !sda_d_ff && pin_lvl[SBM_IN_SDA];

   // byte as it stands once the eighth bit is shifted in, msb first
   assign rx_byte = {shift_ff[SBM_DW-2:0], pin_lvl[SBM_IN_SDA]};
   assign dev_match = (rx_byte[SBM_TYPE_MSB:SBM_TYPE_LSB] == DEV_TYPE)
      && (rx_byte[SBM_SEL_MSB:SBM_SEL_LSB] == pin_lvl[SBM_IN_SEL_MSB:SBM_IN_SEL_LSB]);

   // commit of a data byte, blocked while write protect is high
   assign wr_pulse = scl_rise && !start_seen && !stop_seen && (state_ff == SBM_WDAT)
      && (cnt_ff == SBM_CNT_LAST) && !pin_lvl[SBM_IN_WP];

   // protocol sequencer; start and stop win over every serial clock edge
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_ff <= SBM_IDLE;
         after_ack_ff <= SBM_IDLE;
      end else if (start_seen) begin
         state_ff <= SBM_DEV;
      end else if (stop_seen) begin
         state_ff <= SBM_IDLE;
      end else if (scl_rise) begin
         unique case (state_ff)
            SBM_DEV: begin
               if (cnt_ff == SBM_CNT_LAST) begin
                  // a foreign address leaves the bus alone until the next start
                  state_ff <= dev_match ? SBM_ACK_SET : SBM_IDLE;
                  after_ack_ff <= rx_byte[SBM_RW_BIT] ? SBM_RDAT : SBM_WORD;
               end
            end
            SBM_WORD: begin
               if (cnt_ff == SBM_CNT_LAST) begin
                  state_ff <= SBM_ACK_SET;
                  after_ack_ff <= SBM_WDAT;
               end
            end
            SBM_WDAT: begin
               if (cnt_ff == SBM_CNT_LAST) begin
                  state_ff <= SBM_ACK_SET;
                  after_ack_ff <= SBM_WDAT;
               end
            end
            SBM_RDAT: begin
               if (cnt_ff == SBM_CNT_LAST) begin
                  state_ff <= SBM_MREL;
               end
            end
            SBM_MACK: begin
               // master acknowledge low asks for another byte
               state_ff <= pin_lvl[SBM_IN_SDA] ? SBM_IDLE : SBM_MNEXT;
            end
            SBM_IDLE, SBM_ACK_SET, SBM_ACK_HOLD, SBM_MREL, SBM_MNEXT: begin
               state_ff <= state_ff;
            end
         endcase
      end else if (scl_fall) begin
         unique case (state_ff)
            SBM_ACK_SET: state_ff <= SBM_ACK_HOLD;
            SBM_ACK_HOLD: state_ff <= after_ack_ff;
            SBM_MREL: state_ff <= SBM_MACK;
            SBM_MNEXT: state_ff <= SBM_RDAT;
            SBM_IDLE, SBM_DEV, SBM_WORD, SBM_WDAT, SBM_RDAT, SBM_MACK: begin
               state_ff <= state_ff;
            end
         endcase
      end
   end

   // bit counter and receive shifter; counter restarts on each start and before each byte
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_ff <= SBM_CNT_RST;
         shift_ff <= SBM_BYTE_RST;
      end else if (start_seen || stop_seen) begin
         cnt_ff <= SBM_CNT_RST;
      end else if (scl_rise && (state_ff == SBM_DEV || state_ff == SBM_WORD
            || state_ff == SBM_WDAT || state_ff == SBM_RDAT)) begin
         shift_ff <= rx_byte;
         cnt_ff <= cnt_ff + 3'h1; // wraps to zero after the eighth bit
      end
   end

   // address latch: page from the slave byte, word from the second byte, step per data byte
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         addr_ff <= SBM_ADDR_RST;
         page_ff <= SBM_BIT_RST;
      end else if (scl_rise && !start_seen && !stop_seen && cnt_ff == SBM_CNT_LAST) begin
         unique case (state_ff)
            SBM_DEV: begin
               if (dev_match) begin
                  page_ff <= rx_byte[SBM_PAGE_BIT];
                  // reads keep the low eight bits already held
                  addr_ff[SBM_AW-1] <= rx_byte[SBM_PAGE_BIT];
               end
            end
            SBM_WORD: addr_ff <= {page_ff, rx_byte};
            // 9-bit add rolls 1ffh over to 000h; also steps when protected
            SBM_WDAT, SBM_RDAT: addr_ff <= addr_ff + 9'h001;
            SBM_IDLE, SBM_ACK_SET, SBM_ACK_HOLD, SBM_MREL, SBM_MACK, SBM_MNEXT: addr_ff <= addr_ff;
         endcase
      end
   end

   // data line driver: acknowledge and read bits only ever pull low
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sda_out_ff <= SBM_BIT_RST;
         sda_oe_ff <= SBM_BIT_RST;
         tx_ff <= SBM_BYTE_RST;
      end else if (start_seen || stop_seen) begin
         sda_oe_ff <= SBM_BIT_RST;
      end else if (scl_fall) begin
         unique case (state_ff)
            SBM_ACK_SET: sda_oe_ff <= 1'b1;
            SBM_ACK_HOLD: begin
               // a read starts its first bit right as the acknowledge ends
               if (after_ack_ff == SBM_RDAT) begin
                  tx_ff <= rd_data;
                  sda_oe_ff <= !rd_data[SBM_DW-1];
               end else begin
                  sda_oe_ff <= SBM_BIT_RST;
               end
            end
            SBM_RDAT: begin
               sda_oe_ff <= !tx_ff[SBM_DW-2];
               tx_ff <= {tx_ff[SBM_DW-2:0], SBM_BIT_RST};
            end
            SBM_MNEXT: begin
               // address already stepped, so the array holds the next byte
               tx_ff <= rd_data;
               sda_oe_ff <= !rd_data[SBM_DW-1];
            end
            // release for the master acknowledge slot
            SBM_MREL, SBM_IDLE, SBM_DEV, SBM_WORD, SBM_WDAT, SBM_MACK: sda_oe_ff <= SBM_BIT_RST;
         endcase
      end
   end

   // storage array; written on the eighth bit's rising edge, read always at the latch
   sbm_mem #(
      .DW(SBM_DW),
      .AW(SBM_AW),
      .DEPTH(SBM_DEPTH)
   ) u_mem (
      .core_clk(core_clk),
      .wr_en(wr_pulse),
      .wr_addr(addr_ff),
      .wr_data(rx_byte),
      .rd_addr(addr_ff),
      .rd_data_ff(rd_data)
   );
endmodule

// [tb/sbm_top_sva.sv]
// Purpose: pin level checks on the serial byte memory slave
// Assumes: master holds data steady while the serial clock is high
// Notes: helper counters run on raw pins, so latency windows are a little wide
`timescale 1ns/1ns
module sbm_top_sva #(
   parameter logic [3:0] DEV_TYPE = 4'h6
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic scl_pin,
   input wire logic sda_in,
   input wire logic [1:0] device_select_straps,
   input wire logic write_protect,
   input wire logic sda_out_ff,
   input wire logic sda_oe_ff
);
   logic scl_q_ff, sda_q_ff, stop_seen_ff;
   logic [7:0] shift_ff;
   logic [4:0] rises_ff, since_fall_ff;
   wire start_c = scl_pin & scl_q_ff & sda_q_ff & ~sda_in;
   wire stop_c = scl_pin & scl_q_ff & ~sda_q_ff & sda_in;
   wire match_c = (shift_ff[7:4] == DEV_TYPE) && (shift_ff[3:2] == device_select_straps);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // last pin levels and the received bits, shifted at each clock rise
   always_ff @(posedge core_clk) begin
      scl_q_ff <= scl_pin;
      sda_q_ff <= sda_in;
      if (scl_pin && !scl_q_ff) shift_ff <= {shift_ff[6:0], sda_in};
   end
   // rises since start, cycles since the last fall; saturate so long idle cannot wrap
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rises_ff <= 5'h00;
         since_fall_ff <= 5'h1f;
         stop_seen_ff <= 1'b1;
      end else begin
         if (start_c) rises_ff <= 5'h00;
         else if (scl_pin && !scl_q_ff && rises_ff != 5'h1f) rises_ff <= rises_ff + 5'h01;
         if (!scl_pin && scl_q_ff) since_fall_ff <= 5'h00;
         else if (since_fall_ff != 5'h1f) since_fall_ff <= since_fall_ff + 5'h01;
         if (stop_c) stop_seen_ff <= 1'b1;
         else if (start_c) stop_seen_ff <= 1'b0;
      end
   end
   // slave byte for this device is complete and the ack slot opens
   sequence s_slave_done;
      $fell(scl_pin) && rises_ff == 5'h08 && match_c;
   endsequence
   a_drive_low: assert property (sda_oe_ff |-> !sda_out_ff)
      else $error("data line driven high");
   a_reset_quiet: assert property (@(posedge core_clk) disable iff (1'b0) !rst_n |=> !sda_oe_ff)
      else $error("data line pulled during reset");
   a_change_timing: assert property ($changed(sda_oe_ff) |-> since_fall_ff inside {[2:8]})
      else $error("data drive changed away from a clock fall");
   a_change_low: assert property ($changed(sda_oe_ff) |-> !scl_pin)
      else $error("data drive changed while clock high");
   a_ack_late: assert property ($rose(sda_oe_ff) |-> rises_ff >= 5'h08)
      else $error("data line pulled before a whole byte");
   a_ack_select: assert property ($rose(sda_oe_ff) && rises_ff == 5'h08 |-> match_c)
      else $error("ack given to another slave byte");
   a_ack_given: assert property (s_slave_done |-> ##[2:8] sda_oe_ff)
      else $error("no ack for a matching slave byte");
   a_stop_quiet: assert property (stop_seen_ff |-> !sda_oe_ff)
      else $error("data line pulled after stop");
endmodule
bind sbm_top sbm_top_sva #(.DEV_TYPE(DEV_TYPE)) u_sva (.core_clk(core_clk), .rst_n(rst_n), .scl_pin(scl_pin),
   .sda_in(sda_in), .device_select_straps(device_select_straps), .write_protect(write_protect),
   .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff));

// [tb/sbm_bus_master.sv]
// Purpose: behavioural two-wire bus master driving the serial byte memory
// Assumes: called from the bench just after a falling core clock edge
// Notes: releasing the data line lets the pull-up win, it is never driven high
`timescale 1ns/1ns
module sbm_bus_master (
   input wire logic core_clk,
   input wire logic sda_wire,
   output logic scl,
   output logic m_low
);
   // quarter bit in core cycles, a bit under 1 MHz; rate_div stretches it for the slower legacy rates
   localparam int Q = 7;
   int rate_div = 1;
   initial begin
      scl = 1'b1;
      m_low = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n * rate_div) @(negedge core_clk);
   endtask
   // one bit slot: data set while clock low, line sensed mid high phase
   task automatic bit_io(input logic drv, output logic s);
      m_low = !drv;
      hold(Q);
      scl = 1'b1;
      hold(Q);
      s = sda_wire;
      hold(Q);
      scl = 1'b0;
      hold(Q);
   endtask
   task automatic start();
      m_low = 1'b0;
      hold(Q);
      scl = 1'b1;
      hold(Q);
      m_low = 1'b1;
      hold(Q);
      scl = 1'b0;
      hold(Q);
   endtask
   task automatic stop();
      m_low = 1'b1;
      hold(Q);
      scl = 1'b1;
      hold(Q);
      m_low = 1'b0;
      hold(2 * Q);
   endtask
   // msb first; a short count leaves the byte cut off with no ack slot
   task automatic wbyte(input logic [7:0] b, input int n, output logic ack);
      logic s;
      ack = 1'b1;
      for (int i = 7; i > 7 - n; i--) bit_io(b[i], s);
      if (n == 8) bit_io(1'b1, ack);
   endtask
   task automatic rbyte(output logic [7:0] b, input logic last);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         b[i] = s;
      end
      bit_io(last, s);
   endtask
endmodule

// [tb/tb_top.sv]
// Purpose: random and corner traffic through the serial byte memory slave
// Assumes: bus master model drives the pins, a shadow array holds expectations
// Notes: the shadow follows the 9-bit latch, so reads roll on across pages and from 1ffh to 000h
`timescale 1ns/1ns
module tb_top;
   import sbm_pkg::*;
   localparam logic [3:0] TYPE = 4'h6; // device type code; value is arbitrary
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic write_protect = 1'b0;
   logic [1:0] device_select_straps = 2'h0; // unconnected straps read as low
   logic scl, m_low, sda_out_ff, sda_oe_ff, ack;
   logic [7:0] d;
   logic [8:0] a;
   logic [7:0] mem [SBM_DEPTH];
   int n, seed;
   int err_count = 0;
   int total_checks = 0;
   // wired-and with a pull-up; a high drive by the device would look like a released line
   wire sda_w = !m_low && (sda_out_ff || !sda_oe_ff);
   always #20 core_clk = !core_clk;
   sbm_top #(.DEV_TYPE(TYPE)) dut (.core_clk(core_clk), .rst_n(rst_n), .scl_pin(scl), .sda_in(sda_w),
      .device_select_straps(device_select_straps), .write_protect(write_protect), .sda_out_ff(sda_out_ff),
      .sda_oe_ff(sda_oe_ff));
   sbm_bus_master m (.core_clk(core_clk), .sda_wire(sda_w), .scl(scl), .m_low(m_low));
   function automatic logic [7:0] slave(logic [1:0] sel, logic pg, logic rd);
      return {TYPE, sel, pg, rd};
   endfunction
   // a read steps the whole 9-bit latch, so 0ffh runs into 100h and 1ffh rolls to 000h
   function automatic logic [7:0] exp_at(logic [8:0] base, int i);
      return mem[9'(base + i)];
   endfunction
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_ack(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask
   // write n random bytes from base; the shadow copy follows unless protected
   task automatic wr(input logic [8:0] base, input int cnt);
      m.start();
      m.wbyte(slave(device_select_straps, base[8], 1'b0), 8, ack);
      chk_ack(ack, 1'b0);
      m.wbyte(base[7:0], 8, ack);
      chk_ack(ack, 1'b0);
      for (int i = 0; i < cnt; i++) begin
         d = 8'($urandom);
         m.wbyte(d, 8, ack);
         chk_ack(ack, 1'b0);
         if (!write_protect) mem[base] = d;
         base = base + 9'h001;
      end
      m.stop();
   endtask
   task automatic rd(input logic [8:0] base, input int cnt);
      wr(base, 0);
      m.start();
      m.wbyte(slave(device_select_straps, base[8], 1'b1), 8, ack);
      chk_ack(ack, 1'b0);
      for (int i = 0; i < cnt; i++) begin
         m.rbyte(d, i == cnt - 1);
         chk_byte(d, exp_at(base, i));
      end
      m.stop();
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      seed = $urandom(20);
      repeat (5) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (5) @(negedge core_clk);
      // top of the array, the latch wraps to zero
      wr(9'h1fe, 4);
      rd(9'h1fe, 2);
      rd(9'h1ff, 2);
      rd(9'h000, 2);
      $display("test wrap done");
      // protected writes are acked but leave bytes alone
      write_protect = 1'b1;
      wr(9'h1fe, 2);
      write_protect = 1'b0;
      rd(9'h1fe, 2);
      $display("test protect done");
      // wrong straps, then wrong type: no ack
      for (int i = 0; i < 2; i++) begin
         m.start();
         m.wbyte(i ? {~TYPE, device_select_straps, 2'h0} : slave(~device_select_straps, 1'b0, 1'b0), 8, ack);
         chk_ack(ack, 1'b1);
         m.stop();
      end
      $display("test select done");
      // half a data byte cut off by a start, a stop or a reset is dropped
      for (int k = 0; k < 3; k++) begin
         m.start();
         m.wbyte(slave(device_select_straps, 1'b0, 1'b0), 8, ack);
         m.wbyte(8'h00, 8, ack);
         m.wbyte(~mem[0], 4, ack);
         if (k == 0) begin
            m.start();
         end else if (k == 2) begin
            // reset in mid byte; the bus waits until the synchronisers have flushed
            rst_n = 1'b0;
            repeat (5) @(negedge core_clk);
            rst_n = 1'b1;
            repeat (5) @(negedge core_clk);
         end
         m.stop();
         rd(9'h000, 1);
      end
      $display("test abort done");
      // slower legacy rates; the read crosses 0ffh into the upper page
      for (int k = 0; k < 2; k++) begin
         m.rate_div = k ? 9 : 2;
         wr(9'h0ff, 2);
         rd(9'h0ff, 2);
      end
      m.rate_div = 1;
      $display("test rate done");
      // random straps, addresses and lengths, read back at once
      repeat (6) begin
         device_select_straps = 2'($urandom);
         a = {1'($urandom), 8'($urandom % 250)};
         n = 1 + $urandom % 3;
         wr(a, n);
         rd(a, n);
      end
      $display("test random done");
      end_of_test();
   end
   // watchdog: the tests need well under this many cycles
   initial begin
      repeat (90000) @(posedge core_clk);
      err_count++;
      end_of_test();
   end
endmodule
